// *** port_ctrl_pkg.sv ***
// package: offsets, field layout, reset values and types for the port control bank
package port_ctrl_pkg;
  localparam int unsigned NUM_FRONT    = 16;
  localparam int unsigned NUM_PORTS    = 17;
  localparam logic [7:0]  OFS_FRONT0   = 8'h00;
  localparam logic [7:0]  OFS_MGMT     = 8'h10;
  localparam logic [7:0]  OFS_SWMODE   = 8'h20;
  localparam logic [7:0]  OFS_FLUSH    = 8'h52;
  localparam logic [7:0]  FLUSH_TX_OFF = 8'h02;
  localparam int unsigned TS_HI        = 7;
  localparam int unsigned TS_LO        = 5;
  localparam int unsigned UC_BIT       = 4;
  localparam int unsigned MC_BIT       = 3;
  localparam int unsigned BC_BIT       = 2;
  localparam int unsigned TXD_BIT      = 1;
  localparam int unsigned RXD_BIT      = 0;
  localparam int unsigned MODE_BIT     = 0;
  localparam logic [7:0]  FRONT_WMASK  = 8'he3;
  localparam logic [7:0]  FLUSH_RST    = 8'h00;
  localparam logic [1:0]  STRAP_WAIT   = 2'h2;

  typedef enum logic [2:0] {
    TS_NONE = 3'h0, TS_DIS = 3'h1, TS_BLK = 3'h2,
    TS_LIS  = 3'h3, TS_LRN = 3'h4, TS_FWD = 3'h5
  } tree_state_t;

  // per-port gate outputs toward the forwarding logic
  typedef struct packed {
    logic fwd_en;
    logic learn_en;
    logic tx_off;
    logic rx_off;
  } port_gate_t;

  // management port receive steering
  typedef struct packed {
    logic flood_uc;
    logic flood_mc;
    logic bcast;
  } mgmt_rx_t;
endpackage

// *** port_stp_and_mac_enable_control.sv ***
// port tree-state and mac enable control registers on a classic wishbone slave
//
// Operation
// - sixteen 8-bit front port registers at 00h-0Fh
// - management port register at 10h, same layout
// - decode tree codes; reset 001 managed, 000 unmanaged
// - management tree state ignored in unmanaged mode
// - bit 1 requests mac transmit shut-off
// - transmit shut-off needs flush register 52h = 02h
// - bit 0 disables mac receive
// - bit 4 admits flooded unicast to management port
// - mirrored unicast still reaches management port
// - bit 3 admits flooded multicast to management port
// - mirrored multicast still reaches management port
// - bit 2 admits broadcast to management port
// - receive enables ignored unless management port selected
// - mode select loads inverted strap, software writable
//
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/100ps
module port_stp_and_mac_enable_control
  import port_ctrl_pkg::*;
(
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [7:0]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  input  wire logic                 forwarding_strap_pin_i,
  input  wire logic                 mgmt_is_frame_port_i,
  input  wire logic                 uc_flooded_i,
  input  wire logic                 mc_flooded_i,
  input  wire logic                 bcast_i,
  input  wire logic                 mirror_hit_i,
  output port_gate_t [NUM_PORTS-1:0] port_gate_o,
  output mgmt_rx_t                  mgmt_rx_o,
  output logic                      forwarding_mode_select_o
);

  // ==========================================================
  // decode helpers
  // reserved codes fold onto disabled so nothing leaks through
  function automatic logic [1:0] gate_of(input logic [2:0] ts, input logic managed);
    logic [1:0] g;
    g = 2'b00;
    unique case (ts)
      TS_NONE: g = 2'b11;                     // no tree: learn and forward
      TS_DIS, TS_BLK, TS_LIS: g = 2'b00;      // drop, no learning
      TS_LRN: g = 2'b01;                      // learn only
      TS_FWD: g = 2'b11;                      // learn and forward
      default: g = 2'b00;                     // reserved as disabled
    endcase
    if (!managed) g = 2'b11;
    return g;
  endfunction

  // ==========================================================
  // strap pin synchroniser and power-on capture
  logic       strap_s1_reg, strap_s2_reg;
  logic [1:0] strap_cnt_reg, strap_cnt_next;
  logic       strap_done_reg, strap_done_next;

  // the strap comes from a board pin so it passes two flops first
  always_ff @(posedge clk_i) begin
    strap_s1_reg <= forwarding_strap_pin_i;
    strap_s2_reg <= strap_s1_reg;
  end

  always_comb begin
    strap_cnt_next  = strap_cnt_reg;
    strap_done_next = strap_done_reg;
    if (!strap_done_reg) begin
      if (strap_cnt_reg == STRAP_WAIT) strap_done_next = 1'b1;
      else strap_cnt_next = strap_cnt_reg + 2'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strap_cnt_reg  <= 2'h0;
      strap_done_reg <= 1'b0;
    end else begin
      strap_cnt_reg  <= strap_cnt_next;
      strap_done_reg <= strap_done_next;
    end
  end

  wire strap_load = !strap_done_reg && (strap_cnt_reg == STRAP_WAIT);

  // ==========================================================
  // register bank and wishbone slave
  logic [7:0] ctrl_reg  [NUM_PORTS];
  logic [7:0] ctrl_next [NUM_PORTS];
  logic [7:0] flush_reg, flush_next;
  logic       mode_reg, mode_next;
  logic       ack_reg, ack_next;
  logic [31:0] rdat_reg, rdat_next;

  wire req   = wb_cyc_i && wb_stb_i && !ack_reg;
  wire wr_b0 = req && wb_we_i && wb_sel_i[0];

  // writes and reads take effect on the ack edge; one wait state
  always_comb begin
    for (int i = 0; i < NUM_PORTS; i++) ctrl_next[i] = ctrl_reg[i];
    flush_next = flush_reg;
    mode_next  = mode_reg;
    ack_next   = req;
    rdat_next  = rdat_reg;
    if (strap_load) begin
      mode_next = !strap_s2_reg;                          // inverse of strap
      for (int i = 0; i < NUM_PORTS; i++)
        ctrl_next[i] = {(strap_s2_reg ? 3'h0 : 3'h1), 5'h00}; // managed resets to 001
    end
    if (wr_b0) begin
      if (wb_adr_i < OFS_MGMT)
        ctrl_next[wb_adr_i[3:0]] = wb_dat_i[7:0] & FRONT_WMASK;
      else if (wb_adr_i == OFS_MGMT)
        ctrl_next[NUM_FRONT] = wb_dat_i[7:0];
      else if (wb_adr_i == OFS_SWMODE)
        mode_next = wb_dat_i[MODE_BIT];                   // software overwrite
      else if (wb_adr_i == OFS_FLUSH)
        flush_next = wb_dat_i[7:0];
    end
    if (req) begin
      rdat_next = 32'h0000_0000;                           // unmapped reads zero
      if (wb_adr_i <= OFS_MGMT) rdat_next[7:0] = ctrl_reg[wb_adr_i[4:0]];
      else if (wb_adr_i == OFS_SWMODE) rdat_next[MODE_BIT] = mode_reg;
      else if (wb_adr_i == OFS_FLUSH) rdat_next[7:0] = flush_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NUM_PORTS; i++) ctrl_reg[i] <= 8'h00;  // enables reset zero
      flush_reg <= FLUSH_RST;
      mode_reg  <= 1'b0;
      ack_reg   <= 1'b0;
      rdat_reg  <= 32'h0000_0000;
    end else begin
      for (int i = 0; i < NUM_PORTS; i++) ctrl_reg[i] <= ctrl_next[i];
      flush_reg <= flush_next;
      mode_reg  <= mode_next;
      ack_reg   <= ack_next;
      rdat_reg  <= rdat_next;
    end
  end

  assign wb_ack_o                 = ack_reg;
  assign wb_dat_o                 = rdat_reg;
  assign forwarding_mode_select_o = mode_reg;

  // ==========================================================
  // gate outputs, registered so every output leaves a flop
  port_gate_t [NUM_PORTS-1:0] gate_reg, gate_next;
  mgmt_rx_t                   mrx_reg, mrx_next;

  always_comb begin
    logic [1:0] g;
    logic       mg;
    logic [7:0] m;
    g  = 2'b00;
    m  = ctrl_reg[NUM_FRONT];
    mg = mgmt_is_frame_port_i;
    for (int i = 0; i < NUM_PORTS; i++) begin
      // management tree state counts only when managed
      g = gate_of(ctrl_reg[i][TS_HI:TS_LO], (i == NUM_FRONT) ? mode_reg : 1'b1);
      gate_next[i].fwd_en   = g[1];
      gate_next[i].learn_en = g[0];
      gate_next[i].tx_off   = ctrl_reg[i][TXD_BIT] && (flush_reg == FLUSH_TX_OFF);
      gate_next[i].rx_off   = ctrl_reg[i][RXD_BIT];
    end
    // enables only matter when the port is the frame management port
    mrx_next.flood_uc = mg && uc_flooded_i && (m[UC_BIT] || mirror_hit_i);
    mrx_next.flood_mc = mg && mc_flooded_i && (m[MC_BIT] || mirror_hit_i);
    mrx_next.bcast    = mg && bcast_i && (m[BC_BIT] || mirror_hit_i);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gate_reg <= '0;
      mrx_reg  <= '0;
    end else begin
      gate_reg <= gate_next;
      mrx_reg  <= mrx_next;
    end
  end

  assign port_gate_o = gate_reg;
  assign mgmt_rx_o   = mrx_reg;

  // ==========================================================
  // assertions
  property p_front_rsvd;
    @(posedge clk_i) disable iff (rst_i)
      wb_ack_o && $past(!wb_we_i && wb_adr_i < OFS_MGMT) |-> wb_dat_o[4:2] == 3'h0;
  endproperty
  a_front_rsvd: assert property (p_front_rsvd) else $error("front reserved bits nonzero");

  property p_ack_one;
    @(posedge clk_i) disable iff (rst_i) wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack held two cycles");

  property p_mgmt_write;
    @(posedge clk_i) disable iff (rst_i)
      wr_b0 && wb_adr_i == OFS_MGMT && !strap_load |=> ctrl_reg[NUM_FRONT] == $past(wb_dat_i[7:0]);
  endproperty
  a_mgmt_write: assert property (p_mgmt_write) else $error("mgmt register write lost");

  property p_tx_needs_flush;
    @(posedge clk_i) disable iff (rst_i)
      port_gate_o[0].tx_off |-> $past(flush_reg) == FLUSH_TX_OFF && $past(ctrl_reg[0][TXD_BIT]);
  endproperty
  a_tx_needs_flush: assert property (p_tx_needs_flush) else $error("tx off without flush mode");

  property p_rx_off;
    @(posedge clk_i) disable iff (rst_i) ctrl_reg[3][RXD_BIT] |=> port_gate_o[3].rx_off;
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("rx disable not applied");

  property p_not_frame_port;
    @(posedge clk_i) disable iff (rst_i) !mgmt_is_frame_port_i |=> mgmt_rx_o == '0;
  endproperty
  a_not_frame_port: assert property (p_not_frame_port) else $error("mgmt rx without frame port");

  property p_rsvd_drop;
    @(posedge clk_i) disable iff (rst_i)
      ctrl_reg[2][TS_HI:TS_LO] inside {3'h6, 3'h7} |=> !port_gate_o[2].fwd_en && !port_gate_o[2].learn_en;
  endproperty
  a_rsvd_drop: assert property (p_rsvd_drop) else $error("reserved code forwarded");

  property p_learn_only;
    @(posedge clk_i) disable iff (rst_i)
      ctrl_reg[1][TS_HI:TS_LO] == TS_LRN |=> port_gate_o[1].learn_en && !port_gate_o[1].fwd_en;
  endproperty
  a_learn_only: assert property (p_learn_only) else $error("learning state wrong");

  property p_mgmt_unmanaged;
    @(posedge clk_i) disable iff (rst_i) !mode_reg |=> port_gate_o[NUM_FRONT].fwd_en;
  endproperty
  a_mgmt_unmanaged: assert property (p_mgmt_unmanaged) else $error("mgmt state used unmanaged");

  property p_strap;
    @(posedge clk_i) disable iff (rst_i) strap_load |=> mode_reg == !$past(strap_s2_reg);
  endproperty
  a_strap: assert property (p_strap) else $error("mode not inverse of strap");

  property p_ack_follows;
    @(posedge clk_i) disable iff (rst_i)
      req |=> wb_ack_o;
  endproperty
  a_ack_follows: assert property (p_ack_follows) else $error("request not acknowledged");

  // one fixed port keeps the index static; reserved bits must come back clear
  property p_front_write;
    @(posedge clk_i) disable iff (rst_i)
      wr_b0 && wb_adr_i == 8'h05 && !strap_load |=> ctrl_reg[5] == ($past(wb_dat_i[7:0]) & FRONT_WMASK);
  endproperty
  a_front_write: assert property (p_front_write) else $error("front register write wrong");

  property p_tx_off_set;
    @(posedge clk_i) disable iff (rst_i)
      ctrl_reg[4][TXD_BIT] && flush_reg == FLUSH_TX_OFF |=> port_gate_o[4].tx_off;
  endproperty
  a_tx_off_set: assert property (p_tx_off_set) else $error("tx shut-off not applied");

  property p_fwd_state;
    @(posedge clk_i) disable iff (rst_i)
      ctrl_reg[0][TS_HI:TS_LO] == TS_FWD |=> port_gate_o[0].fwd_en && port_gate_o[0].learn_en;
  endproperty
  a_fwd_state: assert property (p_fwd_state) else $error("forwarding state blocked");

  property p_dis_drop;
    @(posedge clk_i) disable iff (rst_i)
      ctrl_reg[0][TS_HI:TS_LO] inside {TS_DIS, TS_BLK, TS_LIS} |=> !port_gate_o[0].fwd_en && !port_gate_o[0].learn_en;
  endproperty
  a_dis_drop: assert property (p_dis_drop) else $error("non-forwarding state passed traffic");

  property p_uc_flood;
    @(posedge clk_i) disable iff (rst_i)
      mgmt_is_frame_port_i && uc_flooded_i && ctrl_reg[NUM_FRONT][UC_BIT] |=> mgmt_rx_o.flood_uc;
  endproperty
  a_uc_flood: assert property (p_uc_flood) else $error("flooded unicast not delivered");

  property p_mirror_uc;
    @(posedge clk_i) disable iff (rst_i)
      mgmt_is_frame_port_i && uc_flooded_i && mirror_hit_i |=> mgmt_rx_o.flood_uc;
  endproperty
  a_mirror_uc: assert property (p_mirror_uc) else $error("mirrored unicast not delivered");

  property p_mc_flood;
    @(posedge clk_i) disable iff (rst_i)
      mgmt_is_frame_port_i && mc_flooded_i && ctrl_reg[NUM_FRONT][MC_BIT] |=> mgmt_rx_o.flood_mc;
  endproperty
  a_mc_flood: assert property (p_mc_flood) else $error("flooded multicast not delivered");

  property p_mirror_mc;
    @(posedge clk_i) disable iff (rst_i)
      mgmt_is_frame_port_i && mc_flooded_i && mirror_hit_i |=> mgmt_rx_o.flood_mc;
  endproperty
  a_mirror_mc: assert property (p_mirror_mc) else $error("mirrored multicast not delivered");

  property p_bcast;
    @(posedge clk_i) disable iff (rst_i)
      mgmt_is_frame_port_i && bcast_i && ctrl_reg[NUM_FRONT][BC_BIT] |=> mgmt_rx_o.bcast;
  endproperty
  a_bcast: assert property (p_bcast) else $error("broadcast not delivered");

  // a bus write landing on the strap edge wins, so it is kept out of the antecedent
  property p_managed_reset;
    @(posedge clk_i) disable iff (rst_i)
      strap_load && !strap_s2_reg && !wr_b0 |=> ctrl_reg[0][TS_HI:TS_LO] == TS_DIS && mode_reg;
  endproperty
  a_managed_reset: assert property (p_managed_reset) else $error("managed reset state wrong");

  c_write: cover property (@(posedge clk_i) wr_b0 ##1 wb_ack_o);
  c_tx_off: cover property (@(posedge clk_i) port_gate_o[0].tx_off);
  c_uc: cover property (@(posedge clk_i) mgmt_rx_o.flood_uc);
  c_fwd: cover property (@(posedge clk_i) port_gate_o[5].fwd_en && mode_reg);
endmodule

// *** port_stp_and_mac_enable_control_bench.sv ***
// self-checking bench for the port tree-state and mac enable register bank
`timescale 1ns/100ps
module port_stp_and_mac_enable_control_bench;
  import port_ctrl_pkg::*;
  // ==========================================================
  // stimulus, outputs and reference model state
  logic                       clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0]                 wb_adr_i = 8'h00;
  logic [3:0]                 wb_sel_i = 4'h0;
  logic [31:0]                wb_dat_i = 32'h0, wb_dat_o, q;
  logic                       wb_ack_o, forwarding_mode_select_o, m_mode;
  logic                       forwarding_strap_pin_i = 1'b0, mgmt_is_frame_port_i = 1'b0, mirror_hit_i = 1'b0;
  logic                       uc_flooded_i = 1'b0, mc_flooded_i = 1'b0, bcast_i = 1'b0;
  port_gate_t [NUM_PORTS-1:0] port_gate_o;
  mgmt_rx_t                   mgmt_rx_o;
  logic [7:0]                 m_reg [NUM_PORTS];
  logic [7:0]                 m_flush;
  int                         n_errors = 0, n_compared = 0;

  port_stp_and_mac_enable_control port_stp_and_mac_enable_control_i (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .forwarding_strap_pin_i, .mgmt_is_frame_port_i, .uc_flooded_i, .mc_flooded_i, .bcast_i, .mirror_hit_i,
    .port_gate_o, .mgmt_rx_o, .forwarding_mode_select_o);

  // 40 mhz clock
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end

  // ==========================================================
  // reporting
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // ==========================================================
  // wishbone classic cycle; ack and read data are taken at the edge that also releases the request
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
    int i;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= {24'h0, d};
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (wb_ack_o !== 1'b1 && i < 16);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    if (wb_ack_o !== 1'b1) begin
      chk(32'h0, 32'h1, "bus timeout");
      summarize();
    end
  endtask

  // write through the bus and mirror it in the model; front ports lose bits 4:2
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
    bus(1'b1, a, d, s);
    if (s[0] && a < OFS_MGMT) m_reg[a] = d & FRONT_WMASK;
    else if (s[0] && a == OFS_MGMT) m_reg[16] = d;
    else if (s[0] && a == OFS_SWMODE) m_mode = d[MODE_BIT];
    else if (s[0] && a == OFS_FLUSH) m_flush = d;
  endtask

  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 8'h00, 4'hf);
    if (a <= OFS_MGMT) chk(q, {24'h0, m_reg[a]}, "port register read");
    else if (a == OFS_SWMODE) chk(q, {31'h0, m_mode}, "mode read");
    else if (a == OFS_FLUSH) chk(q, {24'h0, m_flush}, "flush read");
    else chk(q, 32'h0, "unmapped read");
  endtask

  // gate outputs settle one cycle after a register change
  task automatic chk_gates();
    port_gate_t e;
    logic [2:0] t;
    @(posedge clk_i);
    #1;
    for (int p = 0; p < NUM_PORTS; p++) begin
      t = m_reg[p][7:5];
      e.fwd_en   = (t == 3'h0 || t == 3'h5) || (p == 16 && !m_mode);
      e.learn_en = (t == 3'h0 || t == 3'h4 || t == 3'h5) || (p == 16 && !m_mode);
      e.tx_off   = m_reg[p][TXD_BIT] && m_flush == FLUSH_TX_OFF;
      e.rx_off   = m_reg[p][RXD_BIT];
      chk({28'h0, port_gate_o[p]}, {28'h0, e}, "port gate");
    end
    chk({31'h0, forwarding_mode_select_o}, {31'h0, m_mode}, "mode output");
  endtask

  // strap stays steady through the whole reset, well past the three cycles asked
  task automatic do_reset(input logic strap);
    @(posedge clk_i);
    forwarding_strap_pin_i <= strap;
    rst_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    m_mode  = !strap;
    m_flush = FLUSH_RST;
    foreach (m_reg[p]) m_reg[p] = {2'h0, !strap, 5'h00};
  endtask

  // ==========================================================
  // main sequence
  initial begin
    logic [7:0] d;
    logic [2:0] e;
    d = 8'($urandom(25));
    do_reset(1'b0);
    for (int a = 0; a <= 16; a++) rd(8'(a));
    rd(OFS_SWMODE);
    rd(OFS_FLUSH);
    rd(8'h11);
    rd(8'h53);
    chk_gates();
    $display("test reset values done");
    for (int r = 0; r < 3; r++) begin
      wr(OFS_FLUSH, r == 1 ? (8'($urandom) | 8'h04) : FLUSH_TX_OFF, 4'h1);
      wr(OFS_SWMODE, 8'($urandom), 4'h1);
      for (int a = 0; a <= 16; a++) wr(8'(a), 8'($urandom), 4'h1);
      for (int a = 0; a <= 16; a++) rd(8'(a));
      chk_gates();
    end
    $display("test random writes done");
    for (int c = 0; c < 16; c++) begin
      wr(OFS_SWMODE, 8'(c % 2), 4'h1);
      wr(8'h00, {3'(c / 2), 5'h03}, 4'h1);
      wr(OFS_MGMT, {3'(c / 2), 5'h1f}, 4'h1);
      chk_gates();
    end
    wr(8'h03, 8'hff, 4'he);
    rd(8'h03);
    $display("test tree codes done");
    for (int k = 0; k < 64; k++) begin
      if (k % 8 == 0) wr(OFS_MGMT, 8'($urandom), 4'h1);
      d = 8'($urandom);
      @(posedge clk_i);
      mgmt_is_frame_port_i <= d[0];
      uc_flooded_i <= d[2:1] == 2'h0;
      mc_flooded_i <= d[2:1] == 2'h1;
      bcast_i      <= d[2:1] == 2'h2;
      mirror_hit_i <= d[3] && d[2:1] != 2'h3;
      @(posedge clk_i);
      #1;
      e[2] = d[0] && d[2:1] == 2'h0 && (d[3] || m_reg[16][UC_BIT]);
      e[1] = d[0] && d[2:1] == 2'h1 && (d[3] || m_reg[16][MC_BIT]);
      e[0] = d[0] && d[2:1] == 2'h2 && (d[3] || m_reg[16][BC_BIT]);
      chk({29'h0, mgmt_rx_o}, {29'h0, e}, "mgmt steering");
    end
    @(posedge clk_i);
    mgmt_is_frame_port_i <= 1'b0;
    mirror_hit_i <= 1'b0;
    $display("test management steering done");
    do_reset(1'b1);
    for (int a = 0; a <= 16; a++) rd(8'(a));
    rd(OFS_SWMODE);
    chk_gates();
    $display("test unmanaged reset done");
    summarize();
  end
endmodule
